// *** pmd_pkg.sv ***
package pmd_pkg;

  // register addresses on the plain management port
  localparam logic [4:0] PMD_ADDR_CTRL = 5'h00;
  localparam logic [4:0] PMD_ADDR_MODE_STAT = 5'h11;
  localparam logic [4:0] PMD_ADDR_EXT_CTRL2 = 5'h13;

  // control register fields
  localparam int PMD_CTRL_RATE_BIT = 13;
  localparam int PMD_CTRL_AN_EN_BIT = 12;
  localparam int PMD_CTRL_DUPLEX_BIT = 8;
  localparam logic [15:0] PMD_CTRL_WR_MASK = 16'h3100;
  localparam logic [15:0] PMD_CTRL_RST = 16'h3000;

  // extended control 2 fields
  localparam int PMD_EXT2_SAVE100_BIT = 0;
  localparam int PMD_EXT2_SAVE10_BIT = 1;
  localparam logic [15:0] PMD_EXT2_WR_MASK = 16'h0003;
  localparam logic [15:0] PMD_EXT2_RST = 16'h0000;

  // ability vector positions
  localparam int PMD_ABL_10HD = 0;
  localparam int PMD_ABL_10FD = 1;
  localparam int PMD_ABL_100HD = 2;
  localparam int PMD_ABL_100FD = 3;
  localparam logic [3:0] PMD_LOCAL_ABL = 4'hF;

  // mode status register fields
  localparam int PMD_STAT_SPEED_BIT = 0;
  localparam int PMD_STAT_DUPLEX_BIT = 1;
  localparam int PMD_STAT_AN_EN_BIT = 2;
  localparam int PMD_STAT_AN_DONE_BIT = 3;
  localparam int PMD_STAT_P100_BIT = 4;
  localparam int PMD_STAT_P10_BIT = 5;

  typedef struct packed {
    logic speed_100;
    logic full_duplex;
  } pmd_mode_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pmd_bus_req_t;

  typedef struct packed {
    logic enc_4b5b;
    logic nrzi;
    logic mlt3;
    logic scramble;
    logic manchester;
    logic serdes;
  } pmd_coding_t;

  typedef enum logic [1:0] {
    PMD_AN_IDLE,
    PMD_AN_WAIT,
    PMD_AN_DONE
  } pmd_an_state_t;

endpackage : pmd_pkg

// *** pmd_mode_ctrl.sv ***
`timescale 1ns/1ps
module pmd_mode_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // management port
  input wire pmd_pkg::pmd_bus_req_t bus_req,
  output logic [15:0] bus_rdata,
  // configuration pins
  input wire logic config_source_select_pin,
  input wire logic autoneg_select_pin,
  input wire logic speed_select_pin,
  input wire logic duplex_select_pin,
  // autoneg exchange
  input wire logic partner_ability_valid,
  input wire logic [3:0] partner_ability,
  output logic [3:0] local_ability,
  // media activity
  input wire logic tx_active,
  input wire logic rx_active,
  // mode and power outputs
  output pmd_pkg::pmd_mode_t mode,
  output logic autoneg_en,
  output logic pwr_100_en,
  output logic pwr_10_en,
  output pmd_pkg::pmd_coding_t coding,
  output logic tx_path_en,
  output logic rx_path_en,
  // mac side status
  output logic crs,
  output logic col,
  output logic loopback_10,
  output logic sqe_test_en
);
  import pmd_pkg::*;

  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:0] ext2_r, ext2_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  pmd_an_state_t an_r, an_nxt;
  pmd_mode_t mode_r, mode_nxt;
  pmd_mode_t an_mode_r, an_mode_nxt;
  logic an_en_r, an_en_nxt;
  logic p100_r, p100_nxt;
  logic p10_r, p10_nxt;
  pmd_coding_t coding_r, coding_nxt;
  logic txp_r, txp_nxt;
  logic rxp_r, rxp_nxt;
  logic crs_r, crs_nxt;
  logic col_r, col_nxt;
  logic lb_r, lb_nxt;
  logic sqe_r, sqe_nxt;
  logic [3:0] common;
  logic [15:0] stat;
  // own abilities, held in a flop so the port is registered
  logic [3:0] abl_r;

  // register file
  always_comb begin
    ctrl_nxt = ctrl_r;
    ext2_nxt = ext2_r;
    rdata_nxt = 16'h0000;
    stat = 16'h0000;
    stat[PMD_STAT_SPEED_BIT] = mode_r.speed_100;
    stat[PMD_STAT_DUPLEX_BIT] = mode_r.full_duplex;
    stat[PMD_STAT_AN_EN_BIT] = an_en_r;
    stat[PMD_STAT_AN_DONE_BIT] = (an_r == PMD_AN_DONE);
    stat[PMD_STAT_P100_BIT] = p100_r;
    stat[PMD_STAT_P10_BIT] = p10_r;
    if (bus_req.wr) begin
      case (bus_req.addr)
        PMD_ADDR_CTRL: ctrl_nxt = bus_req.wdata & PMD_CTRL_WR_MASK;
        PMD_ADDR_EXT_CTRL2: ext2_nxt = bus_req.wdata & PMD_EXT2_WR_MASK;
        default: ;
      endcase
    end
    if (bus_req.rd) begin
      case (bus_req.addr)
        PMD_ADDR_CTRL: rdata_nxt = ctrl_r;
        PMD_ADDR_MODE_STAT: rdata_nxt = stat;
        PMD_ADDR_EXT_CTRL2: rdata_nxt = ext2_r;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= PMD_CTRL_RST;
      ext2_r <= PMD_EXT2_RST;
      rdata_r <= 16'h0000;
      abl_r <= PMD_LOCAL_ABL;
    end else begin
      ctrl_r <= ctrl_nxt;
      ext2_r <= ext2_nxt;
      rdata_r <= rdata_nxt;
      abl_r <= PMD_LOCAL_ABL;
    end
  end

  // autoneg enable source and resolution
  always_comb begin
    common = PMD_LOCAL_ABL & partner_ability;
    // low on the source pin means pin control
    if (!config_source_select_pin) begin
      an_en_nxt = autoneg_select_pin;
    end else begin
      an_en_nxt = ctrl_r[PMD_CTRL_AN_EN_BIT];
    end
    an_nxt = an_r;
    an_mode_nxt = an_mode_r;
    case (an_r)
      PMD_AN_IDLE: begin
        if (an_en_r) begin
          an_nxt = PMD_AN_WAIT;
        end
      end
      PMD_AN_WAIT: begin
        if (!an_en_r) begin
          an_nxt = PMD_AN_IDLE;
        end else if (partner_ability_valid) begin
          an_nxt = PMD_AN_DONE;
          // highest common mode wins; no overlap falls back to 10 half
          if (common[PMD_ABL_100FD]) begin
            an_mode_nxt = '{speed_100: 1'b1, full_duplex: 1'b1};
          end else if (common[PMD_ABL_100HD]) begin
            an_mode_nxt = '{speed_100: 1'b1, full_duplex: 1'b0};
          end else if (common[PMD_ABL_10FD]) begin
            an_mode_nxt = '{speed_100: 1'b0, full_duplex: 1'b1};
          end else begin
            an_mode_nxt = '{speed_100: 1'b0, full_duplex: 1'b0};
          end
        end
      end
      PMD_AN_DONE: begin
        if (!an_en_r) begin
          an_nxt = PMD_AN_IDLE;
        end
      end
      default: an_nxt = PMD_AN_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      an_r <= PMD_AN_IDLE;
      an_mode_r <= '0;
      an_en_r <= 1'b0;
    end else begin
      an_r <= an_nxt;
      an_mode_r <= an_mode_nxt;
      an_en_r <= an_en_nxt;
    end
  end

  // operating mode, power, coding and mac status
  always_comb begin
    if (an_en_r) begin
      mode_nxt = (an_r == PMD_AN_DONE) ? an_mode_r : mode_r;
    end else if (!config_source_select_pin) begin
      mode_nxt = '{speed_100: speed_select_pin, full_duplex: duplex_select_pin};
    end else begin
      mode_nxt = '{speed_100: ctrl_r[PMD_CTRL_RATE_BIT], full_duplex: ctrl_r[PMD_CTRL_DUPLEX_BIT]};
    end
    // only the idle rate is ever gated
    p100_nxt = mode_r.speed_100 | ~ext2_r[PMD_EXT2_SAVE100_BIT];
    p10_nxt = ~mode_r.speed_100 | ~ext2_r[PMD_EXT2_SAVE10_BIT];
    coding_nxt.enc_4b5b = mode_r.speed_100;
    coding_nxt.nrzi = mode_r.speed_100;
    coding_nxt.mlt3 = mode_r.speed_100;
    coding_nxt.scramble = mode_r.speed_100;
    coding_nxt.manchester = ~mode_r.speed_100;
    coding_nxt.serdes = 1'b1;
    txp_nxt = 1'b1;
    rxp_nxt = 1'b1;
    if (mode_r.full_duplex) begin
      crs_nxt = rx_active;
      col_nxt = 1'b0;
      lb_nxt = 1'b0;
      sqe_nxt = 1'b0;
    end else begin
      crs_nxt = tx_active | rx_active;
      col_nxt = tx_active & rx_active;
      lb_nxt = ~mode_r.speed_100 & tx_active;
      sqe_nxt = ~mode_r.speed_100;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= '0;
      p100_r <= 1'b1;
      p10_r <= 1'b1;
      coding_r <= '0;
      txp_r <= 1'b0;
      rxp_r <= 1'b0;
      crs_r <= 1'b0;
      col_r <= 1'b0;
      lb_r <= 1'b0;
      sqe_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      p100_r <= p100_nxt;
      p10_r <= p10_nxt;
      coding_r <= coding_nxt;
      txp_r <= txp_nxt;
      rxp_r <= rxp_nxt;
      crs_r <= crs_nxt;
      col_r <= col_nxt;
      lb_r <= lb_nxt;
      sqe_r <= sqe_nxt;
    end
  end

  assign bus_rdata = rdata_r;
  assign local_ability = abl_r;
  assign mode = mode_r;
  assign autoneg_en = an_en_r;
  assign pwr_100_en = p100_r;
  assign pwr_10_en = p10_r;
  assign coding = coding_r;
  assign tx_path_en = txp_r;
  assign rx_path_en = rxp_r;
  assign crs = crs_r;
  assign col = col_r;
  assign loopback_10 = lb_r;
  assign sqe_test_en = sqe_r;

endmodule : pmd_mode_ctrl

// *** pmd_mode_ctrl_properties.sv ***
`timescale 1ns/1ps
module pmd_mode_ctrl_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pins
  input wire logic config_source_select_pin,
  input wire logic autoneg_select_pin,
  input wire logic tx_active,
  input wire logic rx_active,
  // outputs
  input wire pmd_pkg::pmd_mode_t mode,
  input wire logic autoneg_en,
  input wire logic pwr_100_en,
  input wire logic pwr_10_en,
  input wire pmd_pkg::pmd_coding_t coding,
  input wire logic tx_path_en,
  input wire logic rx_path_en,
  input wire logic crs,
  input wire logic col,
  input wire logic loopback_10,
  input wire logic sqe_test_en
);
  import pmd_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_col_full_off: assert property (mode.full_duplex && $past(mode.full_duplex) |-> !col)
    else $error("col active in full duplex");
  chk_crs_full_rx: assert property (mode.full_duplex && $past(mode.full_duplex) |-> crs == $past(rx_active))
    else $error("crs not receive only in full duplex");
  chk_half_crs_col: assert property (!mode.full_duplex && !$past(mode.full_duplex) |->
    crs == $past(tx_active || rx_active) && col == $past(tx_active && rx_active))
    else $error("crs or col wrong in half duplex");
  chk_loop_sqe_off: assert property (mode.full_duplex && $past(mode.full_duplex) |-> !loopback_10 && !sqe_test_en)
    else $error("loopback or sqe on in full duplex");
  chk_an_hw_pin: assert property (!$past(config_source_select_pin) |-> autoneg_en == $past(autoneg_select_pin))
    else $error("autoneg enable not from pin");
  chk_rate_100_on: assert property (mode.speed_100 && $past(mode.speed_100) && $past(mode.speed_100, 2) |->
    pwr_100_en && coding.enc_4b5b && coding.nrzi && coding.mlt3 && coding.scramble)
    else $error("100M modules off at 100M");
  chk_rate_10_on: assert property (!mode.speed_100 && !$past(mode.speed_100) && !$past(mode.speed_100, 2) &&
    $past(rst_b, 2) |-> pwr_10_en && coding.manchester && coding.serdes)
    else $error("10M modules off at 10M");
  chk_paths_on: assert property ($past(rst_b) |-> tx_path_en && rx_path_en)
    else $error("data path disabled");
endmodule : pmd_mode_ctrl_properties

bind pmd_mode_ctrl pmd_mode_ctrl_properties i_chk (.clk(clk), .rst_b(rst_b),
  .config_source_select_pin(config_source_select_pin), .autoneg_select_pin(autoneg_select_pin),
  .tx_active(tx_active), .rx_active(rx_active), .mode(mode), .autoneg_en(autoneg_en),
  .pwr_100_en(pwr_100_en), .pwr_10_en(pwr_10_en), .coding(coding), .tx_path_en(tx_path_en),
  .rx_path_en(rx_path_en), .crs(crs), .col(col), .loopback_10(loopback_10), .sqe_test_en(sqe_test_en));

// *** pmd_link_partner.sv ***
`timescale 1ns/1ps
module pmd_link_partner (
  // clock
  input wire logic clk,
  // offer from bench
  input wire logic offer_en,
  input wire logic [3:0] offer,
  // ability to the device
  output logic ability_valid,
  output logic [3:0] ability
);
  // idle lines show the inverse of the offer
  always_ff @(posedge clk) begin
    ability_valid <= offer_en;
    ability <= offer_en ? offer : ~offer;
  end
endmodule : pmd_link_partner

// *** pmd_mode_ctrl_test.sv ***
`timescale 1ns/1ps
module pmd_mode_ctrl_test;
  import pmd_pkg::*;
  logic clk, rst_b, cfg_pin, an_pin, spd_pin, dpx_pin, tx, rx, offer_en, pv;
  logic an_en, p100, p10, tx_en, rx_en, crs, col, lb, sqe;
  logic [3:0] offer, pa, local_ability;
  logic [15:0] rdata, d, v;
  pmd_bus_req_t bus_req;
  pmd_mode_t mode;
  pmd_coding_t coding;
  integer seed = 19, failures = 0, total_checks = 0, i, j;
  pmd_mode_ctrl i_dut (.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(rdata),
    .config_source_select_pin(cfg_pin), .autoneg_select_pin(an_pin), .speed_select_pin(spd_pin),
    .duplex_select_pin(dpx_pin), .partner_ability_valid(pv), .partner_ability(pa),
    .local_ability(local_ability), .tx_active(tx), .rx_active(rx), .mode(mode), .autoneg_en(an_en),
    .pwr_100_en(p100), .pwr_10_en(p10), .coding(coding), .tx_path_en(tx_en), .rx_path_en(rx_en),
    .crs(crs), .col(col), .loopback_10(lb), .sqe_test_en(sqe));
  pmd_link_partner i_partner (.clk(clk), .offer_en(offer_en), .offer(offer), .ability_valid(pv), .ability(pa));
  function automatic pmd_mode_t best(input logic [3:0] a);
    best = a[PMD_ABL_100FD] ? 2'h3 : a[PMD_ABL_100HD] ? 2'h2 : a[PMD_ABL_10FD] ? 2'h1 : 2'h0;
  endfunction : best
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic wr(input logic [4:0] a, input logic [15:0] w);
    @(posedge clk);
    bus_req <= '{a, w, 1'b1, 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] r);
    @(posedge clk);
    bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 r = rdata;
  endtask : rd
  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #400000;
    failures++;
    end_of_test;
  end
  initial begin
    {rst_b, cfg_pin, an_pin, spd_pin, dpx_pin, tx, rx, offer_en, offer} = '0;
    bus_req = '0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd(PMD_ADDR_CTRL, d);
    chk(d, PMD_CTRL_RST);
    rd(PMD_ADDR_EXT_CTRL2, d);
    chk(d, PMD_EXT2_RST);
    v = 16'($random(seed));
    wr(PMD_ADDR_CTRL, v);
    rd(PMD_ADDR_CTRL, d);
    chk(d, v & PMD_CTRL_WR_MASK);
    wr(5'h05, 16'hFFFF);
    rd(5'h05, d);
    chk(d, 16'h0000);
    $display("test registers done");
    // hardware config: pin alone decides autoneg
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      an_pin <= ~i[0];
      settle(3);
      chk(16'(an_en), 16'(!i[0]));
    end
    for (i = 0; i < 16; i++) begin
      wr(PMD_ADDR_EXT_CTRL2, 16'(i[3:2]));
      {spd_pin, dpx_pin} <= i[1:0];
      settle(6);
      chk(16'(mode), 16'(i[1:0]));
      chk(16'({p100, p10}), 16'({i[1] | ~i[2], ~i[1] | ~i[3]}));
      chk(16'(coding), i[1] ? 16'h003D : 16'h0003);
      rd(PMD_ADDR_MODE_STAT, d);
      chk(d, 16'({~i[1] | ~i[3], i[1] | ~i[2], 2'b00, i[0], i[1]}));
      for (j = 0; j < 6; j++) begin
        @(posedge clk);
        {tx, rx} <= 2'($random(seed));
        settle(2);
        chk(16'({crs, col, lb, sqe, tx_en, rx_en}),
          16'(dpx_pin ? {rx, 5'h03} : {tx | rx, tx & rx, tx & ~spd_pin, ~spd_pin, 2'h3}));
      end
    end
    $display("test modes done");
    @(posedge clk);
    cfg_pin <= 1'b1;
    an_pin <= 1'b1;
    for (i = 0; i < 6; i++) begin
      @(posedge clk);
      offer <= (i < 2) ? 4'(i * 8) : 4'($random(seed));
      offer_en <= 1'b0;
      wr(PMD_ADDR_CTRL, 16'h0000);
      settle(2);
      chk(16'(an_en), 16'h0000);
      wr(PMD_ADDR_CTRL, 16'h1000);
      @(posedge clk);
      offer_en <= 1'b1;
      settle(8);
      chk(16'(mode), 16'(best(offer & PMD_LOCAL_ABL)));
    end
    chk(16'(local_ability), 16'(PMD_LOCAL_ABL));
    $display("test autoneg done");
    end_of_test;
  end
endmodule : pmd_mode_ctrl_test
